// File: tmr_pkg.sv
package tmr_pkg;

   // -----------------------------------------------------------------
   // count modes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      TMR_MODE_STOP = 2'h0,
      TMR_MODE_FREE = 2'h1,
      TMR_MODE_MOD = 2'h2,
      TMR_MODE_UPDN = 2'h3
   } tmr_mode_type;

   // -----------------------------------------------------------------
   // prescale select encodings
   // -----------------------------------------------------------------
   localparam logic [1:0] TMR_DIV_1 = 2'h0;
   localparam logic [1:0] TMR_DIV_8 = 2'h1;
   localparam logic [1:0] TMR_DIV_32 = 2'h2;
   localparam logic [1:0] TMR_DIV_128 = 2'h3;
   localparam logic [6:0] TMR_DIV_8_TERM = 7'h07;
   localparam logic [6:0] TMR_DIV_32_TERM = 7'h1F;
   localparam logic [6:0] TMR_DIV_128_TERM = 7'h7F;

   // -----------------------------------------------------------------
   // widths and reset values
   // -----------------------------------------------------------------
   localparam int TMR_TICK_SEL_W = 3;
   localparam int TMR_TICK_DIV_W = 7;
   localparam logic [15:0] TMR_COUNT_RESET = 16'h0000;
   localparam logic [15:0] TMR_COUNT_TERM = 16'hFFFF;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      tmr_mode_type count_mode_field;
      logic [1:0] prescale_select;
      logic [TMR_TICK_SEL_W-1:0] tick_speed_select;
   } tmr_ctrl_type;

   typedef struct packed {
      logic rd_low;
      logic wr_low;
      logic wr_ctrl;
      logic clr_ovf;
   } tmr_access_type;

endpackage

// File: tmr_tick_gen.sv
`timescale 1ns/10ps
// tick speed setting only divides the timer tick; system clock untouched
module tmr_tick_gen #(
   parameter int SEL_W = tmr_pkg::TMR_TICK_SEL_W
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // setting
   input wire logic [SEL_W-1:0] i_tick_speed_select,
   // tick out
   output logic o_tick
);

   localparam int DIV_W = (1 << SEL_W);

   initial begin
      if (SEL_W < 1 || SEL_W > 4) begin
         $error("tmr_tick_gen: SEL_W out of range");
      end
   end

   logic [DIV_W-1:0] div_count;
   logic [DIV_W-1:0] next_div_count;
   logic next_tick;
   logic tick;

   always_comb begin
      next_div_count = div_count + {{(DIV_W-1){1'b0}}, 1'b1};
      // tick at system rate divided by 2**select
      next_tick = 1'b0;
      if (i_tick_speed_select == '0) begin
         next_tick = 1'b1;
      end else if (div_count[i_tick_speed_select - 1'b1 -: 1] == 1'b1 &&
            (div_count & ((DIV_W'(1) << i_tick_speed_select) - DIV_W'(1)))
            == ((DIV_W'(1) << i_tick_speed_select) - DIV_W'(1))) begin
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         div_count <= '0;
         tick <= 1'b0;
      end else begin
         div_count <= next_div_count;
         tick <= next_tick;
      end
   end

   assign o_tick = tick;

endmodule // tmr_tick_gen

// File: tmr_counter.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------
// Summary of operation
// - A 16-bit counter steps by one on every active tick edge in free-running mode.
// - Active edges are the tick divided by 1, 8, 32 or 128.
// - Tick speed changes only the tick rate, never the system clock.
// - Reading the low byte latches the upper byte of the counter.
// - Any low-byte write clears the whole counter.
// - Only free-running mode counts; mode zero and the other modes freeze the count.
// - Free-running counts up and wraps from all ones to zero.
// - Free-running sets the overflow flag on reaching all ones.
// - Overflow reaches the cpu flag only with the mask set.
// - The interrupt request needs both mask and enable set.
// -----------------------------------------------------------------
module tmr_counter #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // control write, applied on i_access.wr_ctrl
   input wire tmr_pkg::tmr_ctrl_type i_ctrl,
   input wire tmr_pkg::tmr_access_type i_access,
   // interrupt gating
   input wire logic i_overflow_irq_mask,
   input wire logic i_timer_irq_enable,
   // status
   output tmr_pkg::tmr_ctrl_type o_timer_control,
   output logic [7:0] o_counter_low_byte,
   output logic [7:0] o_counter_high_byte,
   output logic o_overflow_flag,
   output logic o_cpu_timer_irq_flag,
   output logic o_irq,
   output logic o_terminal_event
);

   initial begin
      if (WIDTH != 16) begin
         $error("tmr_counter: only a 16-bit counter is supported");
      end
   end

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   tmr_pkg::tmr_ctrl_type ctrl;
   tmr_pkg::tmr_ctrl_type next_ctrl;
   logic [15:0] count;
   logic [15:0] next_count;
   logic [6:0] pre_count;
   logic [6:0] next_pre_count;
   logic [7:0] high_buf;
   logic [7:0] next_high_buf;
   logic ovf;
   logic next_ovf;
   logic cpu_flag;
   logic next_cpu_flag;
   logic term_evt;
   logic next_term_evt;
   logic tick;
   logic active;
   logic running;

   // -----------------------------------------------------------------
   // tick source
   // -----------------------------------------------------------------
   tmr_tick_gen #(
      .SEL_W(tmr_pkg::TMR_TICK_SEL_W)
   ) u_tick (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_tick_speed_select(ctrl.tick_speed_select),
      .o_tick(tick)
   );

   function automatic logic [6:0] div_term(input logic [1:0] sel);
      case (sel)
         tmr_pkg::TMR_DIV_1: div_term = 7'h00;
         tmr_pkg::TMR_DIV_8: div_term = tmr_pkg::TMR_DIV_8_TERM;
         tmr_pkg::TMR_DIV_32: div_term = tmr_pkg::TMR_DIV_32_TERM;
         tmr_pkg::TMR_DIV_128: div_term = tmr_pkg::TMR_DIV_128_TERM;
         default: div_term = 7'h00;
      endcase
   endfunction

   assign running = (ctrl.count_mode_field != tmr_pkg::TMR_MODE_STOP);

   // -----------------------------------------------------------------
   // prescaler
   // -----------------------------------------------------------------
   always_comb begin
      next_pre_count = pre_count;
      active = 1'b0;
      if (tick && running) begin
         if (pre_count >= div_term(ctrl.prescale_select)) begin
            next_pre_count = 7'h00;
            active = 1'b1;
         end else begin
            next_pre_count = pre_count + 7'h01;
         end
      end
   end

   // -----------------------------------------------------------------
   // control, counter and flags
   // -----------------------------------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      next_count = count;
      next_high_buf = high_buf;
      next_ovf = ovf;
      next_cpu_flag = cpu_flag;
      next_term_evt = 1'b0;
      if (i_access.wr_ctrl) begin
         next_ctrl = i_ctrl;
      end
      if (i_access.rd_low) begin
         next_high_buf = count[15:8];
      end
      if (i_access.clr_ovf) begin
         next_ovf = 1'b0;
         next_cpu_flag = 1'b0;
      end
      // halted mode leaves count untouched
      // a low-byte write beats the tick, so no flag on a cleared count
      if (active && !i_access.wr_low) begin
         case (ctrl.count_mode_field)
            tmr_pkg::TMR_MODE_FREE: begin
               next_count = count + 16'h0001;
               if (count + 16'h0001 == tmr_pkg::TMR_COUNT_TERM) begin
                  // set wins over a clear in the same cycle
                  next_ovf = 1'b1;
                  next_term_evt = 1'b1;
                  if (i_overflow_irq_mask) begin
                     next_cpu_flag = 1'b1;
                  end
               end
            end
            default: begin
               // other modes belong to a separate block; hold here
               next_count = count;
            end
         endcase
      end
      if (i_access.wr_low) begin
         next_count = tmr_pkg::TMR_COUNT_RESET;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         ctrl <= '{count_mode_field: tmr_pkg::TMR_MODE_STOP,
                   prescale_select: tmr_pkg::TMR_DIV_1,
                   tick_speed_select: '0};
         count <= tmr_pkg::TMR_COUNT_RESET;
         pre_count <= 7'h00;
         high_buf <= 8'h00;
         ovf <= 1'b0;
         cpu_flag <= 1'b0;
         term_evt <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         count <= next_count;
         pre_count <= next_pre_count;
         high_buf <= next_high_buf;
         ovf <= next_ovf;
         cpu_flag <= next_cpu_flag;
         term_evt <= next_term_evt;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign o_timer_control = ctrl;
   assign o_counter_low_byte = count[7:0];
   // buffered byte, valid only after a low-byte read
   assign o_counter_high_byte = high_buf;
   assign o_overflow_flag = ovf;
   assign o_cpu_timer_irq_flag = cpu_flag;
   assign o_irq = cpu_flag & i_overflow_irq_mask & i_timer_irq_enable;
   assign o_terminal_event = term_evt;

endmodule // tmr_counter

// File: tmr_counter_chk.sv
`timescale 1ns/10ps
module tmr_counter_chk #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // stimulus
   input wire tmr_pkg::tmr_ctrl_type i_ctrl,
   input wire tmr_pkg::tmr_access_type i_access,
   input wire logic i_overflow_irq_mask,
   input wire logic i_timer_irq_enable,
   // status
   input wire tmr_pkg::tmr_ctrl_type o_timer_control,
   input wire logic [7:0] o_counter_low_byte,
   input wire logic [7:0] o_counter_high_byte,
   input wire logic o_overflow_flag,
   input wire logic o_cpu_timer_irq_flag,
   input wire logic o_irq,
   input wire logic o_terminal_event
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   // ----------------------------------------------------------
   // sequences
   // ----------------------------------------------------------
   // two settled cycles, so tick and prescale phase are steady
   sequence s_fast;
      o_timer_control.count_mode_field == tmr_pkg::TMR_MODE_FREE &&
         o_timer_control[4:0] == 5'h00;
   endsequence
   sequence s_halted;
      o_timer_control.count_mode_field == tmr_pkg::TMR_MODE_STOP;
   endsequence

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   a_step_one: assert property (
      s_fast ##1 s_fast ##0 !i_access.wr_low |=>
         o_counter_low_byte == $past(o_counter_low_byte) + 8'h01)
      else $error("count did not step by one");
   a_freeze_stop: assert property (
      s_halted ##1 s_halted ##0 !i_access.wr_low |=>
         $stable(o_counter_low_byte))
      else $error("count moved while stopped");
   a_clear_low: assert property (
      i_access.wr_low |=> o_counter_low_byte == 8'h00)
      else $error("low byte write did not clear");
   a_hold_high: assert property (
      !i_access.rd_low |=> $stable(o_counter_high_byte))
      else $error("high byte buffer changed without read");
   a_term_value: assert property (
      o_terminal_event |-> o_counter_low_byte == 8'hFF && o_overflow_flag)
      else $error("terminal event without full count");
   a_ovf_cause: assert property (
      $rose(o_overflow_flag) |-> o_terminal_event)
      else $error("overflow flag set without terminal count");
   a_ovf_sticky: assert property (
      o_overflow_flag && !i_access.clr_ovf |=> o_overflow_flag)
      else $error("overflow flag dropped");
   a_cpu_mask: assert property (
      $rose(o_cpu_timer_irq_flag) |->
         $past(i_overflow_irq_mask) && o_terminal_event)
      else $error("cpu flag set without mask");
   a_irq_gate: assert property (
      o_irq == (o_cpu_timer_irq_flag && i_overflow_irq_mask &&
         i_timer_irq_enable))
      else $error("irq request gating wrong");
endmodule // tmr_counter_chk

bind tmr_counter tmr_counter_chk #(.WIDTH(WIDTH)) u_chk (.*);

// File: tmr_counter_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
   n_fail++; $display("Error %0t: got %0h want %0h", $time, a, b); end end
module tmr_counter_test;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   tmr_pkg::tmr_ctrl_type i_ctrl = '0;
   tmr_pkg::tmr_access_type i_access = '0;
   logic i_overflow_irq_mask = 1'b0;
   logic i_timer_irq_enable = 1'b0;
   tmr_pkg::tmr_ctrl_type o_timer_control;
   logic [7:0] o_counter_low_byte;
   logic [7:0] o_counter_high_byte;
   logic o_overflow_flag;
   logic o_cpu_timer_irq_flag;
   logic o_irq;
   logic o_terminal_event;
   int n_fail = 0;
   int comparisons = 0;
   logic [15:0] v;
   logic [15:0] w;

   tmr_counter DUT (.*);
   always #10 i_sys_clk = ~i_sys_clk;

   // ----------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------
   task automatic pulse(input tmr_pkg::tmr_access_type a);
      @(posedge i_sys_clk);
      i_access <= a;
      @(posedge i_sys_clk);
      i_access <= '0;
   endtask
   task automatic set_ctrl(input logic [1:0] m, input logic [4:0] dt);
      @(posedge i_sys_clk);
      i_ctrl <= {m, dt};
      i_access <= 4'h2;
      @(posedge i_sys_clk);
      i_access <= '0;
   endtask
   // low byte first, high byte from the buffer afterwards
   task automatic rd(output logic [15:0] r);
      pulse(4'h8);
      @(negedge i_sys_clk);
      r = {o_counter_high_byte, o_counter_low_byte};
   endtask
   // prescaler phase is not cleared, so allow a small slack
   task automatic run(input logic [4:0] dt, input int n, input int e);
      pulse(4'h4);
      set_ctrl(2'h1, dt);
      repeat (n) @(posedge i_sys_clk);
      set_ctrl(2'h0, dt);
      rd(v);
      `CHK(int'(v) >= e - 2 && int'(v) <= e + 2, 1'b1)
   endtask
   task automatic stop_test();
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------
   // tests
   // ----------------------------------------------------------
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      rd(v);
      `CHK(v, 16'h0000)
      `CHK(o_timer_control, 7'h00)
      repeat (20) @(posedge i_sys_clk);
      rd(v);
      `CHK(v, 16'h0000)
      run(5'h00, 512, 513);
      run(5'h08, 512, 64);
      run(5'h10, 512, 16);
      run(5'h18, 1024, 8);
      run(5'h02, 512, 128);
      pulse(4'h4);
      set_ctrl(2'h1, 5'h00);
      repeat (300) @(posedge i_sys_clk);
      pulse(4'h8);
      repeat (300) @(negedge i_sys_clk);
      `CHK(o_counter_high_byte, 8'h01)
      pulse(4'h4);
      set_ctrl(2'h0, 5'h00);
      rd(v);
      `CHK(v < 16'h0008, 1'b1)
      @(posedge i_sys_clk);
      i_overflow_irq_mask <= 1'b1;
      pulse(4'h4);
      set_ctrl(2'h1, 5'h00);
      for (int i = 0; i < 70000 && o_terminal_event !== 1'b1; i++)
         @(negedge i_sys_clk);
      `CHK(o_terminal_event, 1'b1)
      `CHK(o_counter_low_byte, 8'hFF)
      `CHK(o_overflow_flag, 1'b1)
      `CHK(o_cpu_timer_irq_flag, 1'b1)
      `CHK(o_irq, 1'b0)
      @(negedge i_sys_clk);
      `CHK(o_counter_low_byte, 8'h00)
      `CHK(o_terminal_event, 1'b0)
      @(posedge i_sys_clk);
      i_timer_irq_enable <= 1'b1;
      @(negedge i_sys_clk);
      `CHK(o_irq, 1'b1)
      @(posedge i_sys_clk);
      i_overflow_irq_mask <= 1'b0;
      @(negedge i_sys_clk);
      `CHK(o_irq, 1'b0)
      pulse(4'h1);
      @(negedge i_sys_clk);
      `CHK(o_overflow_flag, 1'b0)
      // modes handled elsewhere must hold the count here
      set_ctrl(2'h2, 5'h00);
      rd(v);
      repeat (10) @(posedge i_sys_clk);
      rd(w);
      `CHK(w, v)
      stop_test();
   end

   // about 69k cycles expected
   initial begin
      #1800000;
      n_fail++;
      stop_test();
   end
endmodule // tmr_counter_test
